// [rtl/udpot_core.sv]
// up/down speed reference potentiometer core with register port
// ==========================================================================
`timescale 1ns/1ns
module udpot_core
    import udpot_pkg::*;
#(
    parameter int TICK_CYC = RAMP_TICK_CYC
) (
    // clock and reset
    input  wire logic                  core_clk,
    input  wire logic                  rst_n,
    // register port
    input  wire logic [3:0]            regAddr,
    input  wire logic [31:0]           regWrData,
    input  wire logic                  regWr,
    input  wire logic                  regRd,
    output logic      [31:0]           regRdData_ff,
    // drive side
    input  wire logic [udpot_pkg::NUM_INPUTS-1:0] cmdInPin,
    input  wire logic                  driveEnPin,
    output logic      [udpot_pkg::SPEED_W-1:0]    speedRef_ff,
    output logic                       refValid_ff,
    output logic                       raiseAlarm_ff,
    output logic                       lowerAlarm_ff,
    output logic                       irq_ff
);
    // ======================================================================
    // configuration registers
    logic [31:0]         ctrl_ff;
    logic [15:0]         minSpd_ff, maxSpd_ff, accStep_ff, decStep_ff;
    logic [31:0]         funcLo_ff, funcHi_ff;
    logic [IRQ_W-1:0]    irqStat_ff, irqMask_ff;
    logic [3:0]          appState;
    logic                prevEn_ff;
    logic [23:0]         tick_ff;
    logic                tick;
    logic [NUM_INPUTS:0] syncVec;
    logic                raiseFound, lowerFound, raiseLvl, lowerLvl;
    logic                raiseCmd, lowerCmd, enabled, running, bothCmd;
    logic [16:0]         upSum;
    logic [16:0]         downDiff;
    udpot_dir_e          dir;

    // pins cross into the core clock
    udpot_sync #(.WIDTH(NUM_INPUTS + 1)) u_sync (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .asyncIn  ({driveEnPin, cmdInPin}),
        .syncOut  (syncVec)
    );

    udpot_select #(.NUM(NUM_INPUTS), .FW(FUNC_W)) u_raise (
        .funcSel  ({funcHi_ff, funcLo_ff}),
        .funcCode (FUNC_RAISE),
        .levels   (syncVec[NUM_INPUTS-1:0]),
        .found    (raiseFound),
        .level    (raiseLvl)
    );

    udpot_select #(.NUM(NUM_INPUTS), .FW(FUNC_W)) u_lower (
        .funcSel  ({funcHi_ff, funcLo_ff}),
        .funcCode (FUNC_LOWER),
        .levels   (syncVec[NUM_INPUTS-1:0]),
        .found    (lowerFound),
        .level    (lowerLvl)
    );

    // command decode; lower is asserted at the low level
    always_comb begin
        raiseCmd = raiseFound && raiseLvl;
        lowerCmd = lowerFound && !lowerLvl;
        enabled  = syncVec[NUM_INPUTS];
        bothCmd  = raiseCmd && lowerCmd;
        running  = ctrl_ff[CTRL_RUN_BIT] && raiseFound && lowerFound;
        if (!running || !enabled) begin
            dir = UDPOT_IDLE;
        end else if (lowerCmd) begin
            dir = UDPOT_DOWN;
        end else if (raiseCmd) begin
            dir = UDPOT_UP;
        end else begin
            dir = UDPOT_IDLE;
        end
        upSum    = {1'b0, speedRef_ff} + {1'b0, accStep_ff};
        downDiff = {1'b0, speedRef_ff} - {1'b0, decStep_ff};
    end

    // application state word
    always_comb begin
        if (!raiseFound || !lowerFound) begin
            appState = STATE_BLOCKED;
        end else if (ctrl_ff[CTRL_RUN_BIT]) begin
            appState = STATE_RUNNING;
        end else begin
            appState = STATE_STOPPED;
        end
    end

    // ramp tick divider; ramp rates are steps per tick
    assign tick = (tick_ff == 24'(TICK_CYC - 1));
    always_ff @(posedge core_clk) begin
        if (!rst_n || tick) begin
            tick_ff <= '0;
        end else begin
            tick_ff <= tick_ff + 24'h00_0001;
        end
    end

    // ======================================================================
    // speed reference
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            speedRef_ff <= RST_SPEED;
            prevEn_ff   <= 1'b0;
        end else begin
            prevEn_ff <= enabled;
            if (!enabled && bothCmd && running) begin
                speedRef_ff <= ZERO_SPEED;
            end else if (enabled && !prevEn_ff && !ctrl_ff[CTRL_BACKUP_BIT]) begin
                speedRef_ff <= minSpd_ff;
            end else if (tick && dir == UDPOT_UP) begin
                if (upSum >= {1'b0, maxSpd_ff}) begin
                    speedRef_ff <= maxSpd_ff;
                end else begin
                    speedRef_ff <= upSum[15:0];
                end
            end else if (tick && dir == UDPOT_DOWN) begin
                if (downDiff[16] || downDiff[15:0] <= minSpd_ff) begin
                    speedRef_ff <= minSpd_ff;
                end else begin
                    speedRef_ff <= downDiff[15:0];
                end
            end
        end
    end

    // reference valid only with the embedded source selected
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            refValid_ff   <= 1'b0;
            raiseAlarm_ff <= 1'b0;
            lowerAlarm_ff <= 1'b0;
        end else begin
            refValid_ff   <= running && ctrl_ff[CTRL_SRC_LSB +: 4] == SRC_EMBEDDED;
            raiseAlarm_ff <= !raiseFound;
            lowerAlarm_ff <= !lowerFound;
        end
    end

    // ======================================================================
    // register writes
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ctrl_ff    <= RST_CTRL;
            minSpd_ff  <= RST_MINSPD;
            maxSpd_ff  <= RST_MAXSPD;
            accStep_ff <= RST_ACCSTEP;
            decStep_ff <= RST_DECSTEP;
            funcLo_ff  <= RST_FUNC;
            funcHi_ff  <= RST_FUNC;
            irqMask_ff <= '0;
        end else if (regWr) begin
            if (regAddr == ADDR_CTRL) begin
                ctrl_ff <= regWrData;
            end else if (regAddr == ADDR_MINSPD) begin
                minSpd_ff <= regWrData[15:0];
            end else if (regAddr == ADDR_MAXSPD) begin
                maxSpd_ff <= regWrData[15:0];
            end else if (regAddr == ADDR_ACCSTEP) begin
                accStep_ff <= regWrData[15:0];
            end else if (regAddr == ADDR_DECSTEP) begin
                decStep_ff <= regWrData[15:0];
            end else if (regAddr == ADDR_FUNCLO) begin
                funcLo_ff <= regWrData;
            end else if (regAddr == ADDR_FUNCHI) begin
                funcHi_ff <= regWrData;
            end else if (regAddr == ADDR_IRQMASK) begin
                irqMask_ff <= regWrData[IRQ_W-1:0];
            end
        end
    end

    // sticky events; a new event wins over the clear-on-read
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            irqStat_ff <= '0;
        end else begin
            irqStat_ff <= ((regRd && regAddr == ADDR_IRQSTAT) ? '0 : irqStat_ff)
                        | {(!enabled && bothCmd && running), !lowerFound, !raiseFound};
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(irqStat_ff & irqMask_ff);
        end
    end

    // read data one cycle after the strobe, zero elsewhere
    always_ff @(posedge core_clk) begin
        if (!rst_n || !regRd) begin
            regRdData_ff <= '0;
        end else if (regAddr == ADDR_CTRL) begin
            regRdData_ff <= ctrl_ff;
        end else if (regAddr == ADDR_MINSPD) begin
            regRdData_ff <= {16'h0000, minSpd_ff};
        end else if (regAddr == ADDR_MAXSPD) begin
            regRdData_ff <= {16'h0000, maxSpd_ff};
        end else if (regAddr == ADDR_ACCSTEP) begin
            regRdData_ff <= {16'h0000, accStep_ff};
        end else if (regAddr == ADDR_DECSTEP) begin
            regRdData_ff <= {16'h0000, decStep_ff};
        end else if (regAddr == ADDR_FUNCLO) begin
            regRdData_ff <= funcLo_ff;
        end else if (regAddr == ADDR_FUNCHI) begin
            regRdData_ff <= funcHi_ff;
        end else if (regAddr == ADDR_SPEEDREF) begin
            regRdData_ff <= {16'h0000, speedRef_ff};
        end else if (regAddr == ADDR_STATE) begin
            regRdData_ff <= {28'h000_0000, appState};
        end else if (regAddr == ADDR_IRQSTAT) begin
            regRdData_ff <= {29'h0000_0000, irqStat_ff};
        end else if (regAddr == ADDR_IRQMASK) begin
            regRdData_ff <= {29'h0000_0000, irqMask_ff};
        end else begin
            regRdData_ff <= '0;
        end
    end

    // ======================================================================
    // checks; the label line of each carries the rule it guards
    // a ramp step only counts away from an enable edge, which may reload the reference
    sequence s_up_step;
        tick && dir == UDPOT_UP && !(enabled && !prevEn_ff)
            && upSum < {1'b0, maxSpd_ff};
    endsequence
    sequence s_down_step;
        tick && dir == UDPOT_DOWN && !(enabled && !prevEn_ff)
            && !downDiff[16] && downDiff[15:0] > minSpd_ff;
    endsequence
    sequence s_both_enabled;
        tick && enabled && running && bothCmd && speedRef_ff > minSpd_ff;
    endsequence
    sequence s_disabled_quiet;
        !enabled && !bothCmd;
    endsequence
    sequence s_restart;
        enabled && !prevEn_ff && !ctrl_ff[CTRL_BACKUP_BIT];
    endsequence

    a_ref_upper_bound: assert property (@(posedge core_clk) disable iff (!rst_n)
        (tick && dir == UDPOT_UP) |=> speedRef_ff <= $past(maxSpd_ff))
        else $error("reference above maximum");
    a_ref_lower_bound: assert property (@(posedge core_clk) disable iff (!rst_n)
        (tick && dir == UDPOT_DOWN) |=> speedRef_ff >= $past(minSpd_ff))
        else $error("reference below minimum");
    a_lower_wins: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_both_enabled |=> speedRef_ff < $past(speedRef_ff))
        else $error("both commands did not lower");
    a_hold_idle: assert property (@(posedge core_clk) disable iff (!rst_n)
        (enabled && prevEn_ff && !raiseCmd && !lowerCmd) |=> $stable(speedRef_ff))
        else $error("reference moved without command");
    a_disabled_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
        (!enabled && bothCmd && running) |=> speedRef_ff == ZERO_SPEED)
        else $error("disabled both did not zero");
    a_disabled_ignore: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_disabled_quiet |=> $stable(speedRef_ff))
        else $error("disabled reference moved");
    a_raise_alarm: assert property (@(posedge core_clk) disable iff (!rst_n)
        !raiseFound |=> raiseAlarm_ff && !refValid_ff)
        else $error("raise alarm missing");
    a_lower_alarm: assert property (@(posedge core_clk) disable iff (!rst_n)
        !lowerFound |=> lowerAlarm_ff && !refValid_ff)
        else $error("lower alarm missing");
    a_restart_min: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_restart |=> speedRef_ff == $past(minSpd_ff))
        else $error("no restart at minimum");
    a_state_code: assert property (@(posedge core_clk) disable iff (!rst_n)
        (raiseFound && lowerFound)
        |-> appState == (ctrl_ff[CTRL_RUN_BIT] ? STATE_RUNNING : STATE_STOPPED))
        else $error("bad state code");
    a_raise_step: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_up_step |=> speedRef_ff == $past(upSum[15:0]))
        else $error("raise step wrong");
    a_lower_step: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_down_step |=> speedRef_ff == $past(downDiff[15:0]))
        else $error("lower step wrong");
    // the valid flag is one cycle behind the control word it was built from
    a_valid_source: assert property (@(posedge core_clk) disable iff (!rst_n)
        refValid_ff |-> $past(ctrl_ff[CTRL_SRC_LSB +: 4]) == SRC_EMBEDDED)
        else $error("valid without embedded source");
    // a status read must not swallow an alarm that is still standing
    a_event_wins: assert property (@(posedge core_clk) disable iff (!rst_n)
        (regRd && regAddr == ADDR_IRQSTAT && !raiseFound) |=> irqStat_ff[IRQ_RAISE_BIT])
        else $error("status clear beat the alarm event");
endmodule

// [shared/udpot_pkg.sv]
// constants and types for the up/down speed reference potentiometer
package udpot_pkg;
    // ======================================================================
    // register map (word addresses of the plain register port)
    localparam logic [3:0] ADDR_CTRL     = 4'h0;
    localparam logic [3:0] ADDR_MINSPD   = 4'h1;
    localparam logic [3:0] ADDR_MAXSPD   = 4'h2;
    localparam logic [3:0] ADDR_ACCSTEP  = 4'h3;
    localparam logic [3:0] ADDR_DECSTEP  = 4'h4;
    localparam logic [3:0] ADDR_FUNCLO   = 4'h5;
    localparam logic [3:0] ADDR_FUNCHI   = 4'h6;
    localparam logic [3:0] ADDR_SPEEDREF = 4'h7;
    localparam logic [3:0] ADDR_STATE    = 4'h8;
    localparam logic [3:0] ADDR_IRQSTAT  = 4'h9;
    localparam logic [3:0] ADDR_IRQMASK  = 4'hA;
    // ======================================================================
    // field positions and codes
    localparam int          CTRL_RUN_BIT    = 0;
    localparam int          CTRL_BACKUP_BIT = 1;
    localparam int          CTRL_SRC_LSB    = 4;
    localparam int          FUNC_W          = 8;
    localparam int          NUM_INPUTS      = 8;
    localparam int          SPEED_W         = 16;
    localparam logic [7:0]  FUNC_RAISE      = 8'h14;  // code 20
    localparam logic [7:0]  FUNC_LOWER      = 8'h15;  // code 21
    localparam logic [3:0]  SRC_EMBEDDED    = 4'h7;   // code 7
    localparam logic [3:0]  STATE_STOPPED   = 4'h3;
    localparam logic [3:0]  STATE_RUNNING   = 4'h4;
    localparam logic [3:0]  STATE_BLOCKED   = 4'h1;
    // ======================================================================
    // reset values
    localparam logic [15:0] RST_MINSPD      = 16'h0000;
    localparam logic [15:0] RST_MAXSPD      = 16'h4650;  // 18000 rpm
    localparam logic [15:0] RST_ACCSTEP     = 16'h0001;
    localparam logic [15:0] RST_DECSTEP     = 16'h0001;
    localparam logic [15:0] RST_SPEED       = 16'h0000;
    localparam logic [31:0] RST_CTRL        = 32'h0000_0002;  // backup on
    localparam logic [31:0] RST_FUNC        = 32'h0000_0000;
    localparam logic [15:0] ZERO_SPEED      = 16'h0000;
    // ======================================================================
    // ramp tick: one step per millisecond at 10 MHz
    localparam int          CLK_HZ          = 10_000_000;
    localparam int          RAMP_TICK_US    = 1000;
    localparam int          RAMP_TICK_CYC   = CLK_HZ / 1_000_000 * RAMP_TICK_US;
    // interrupt bits
    localparam int          IRQ_RAISE_BIT   = 0;
    localparam int          IRQ_LOWER_BIT   = 1;
    localparam int          IRQ_ZERO_BIT    = 2;
    localparam int          IRQ_W           = 3;

    typedef enum logic [1:0] {
        UDPOT_IDLE = 2'b00,
        UDPOT_UP   = 2'b01,
        UDPOT_DOWN = 2'b11
    } udpot_dir_e;
endpackage

// [rtl/udpot_sync.sv]
// two-stage synchroniser for the isolated command inputs
`timescale 1ns/1ns
module udpot_sync #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    // data
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] meta_ff;

    // first stage feeds only the second
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            meta_ff <= '0;
            syncOut <= '0;
        end else begin
            meta_ff <= asyncIn;
            syncOut <= meta_ff;
        end
    end
endmodule

// [rtl/udpot_select.sv]
// picks the highest-priority input carrying a given function code
`timescale 1ns/1ns
module udpot_select #(
    parameter int NUM = 8,
    parameter int FW  = 8
) (
    // configuration
    input  wire logic [NUM*FW-1:0] funcSel,
    input  wire logic [FW-1:0]     funcCode,
    // inputs and result
    input  wire logic [NUM-1:0]    levels,
    output logic                   found,
    output logic                   level
);
    logic [NUM-1:0] hit;

    // per-input compare
    genvar gi;
    generate
        for (gi = 0; gi < NUM; gi++) begin : g_cmp
            assign hit[gi] = (funcSel[gi*FW +: FW] == funcCode);
        end
    endgenerate

    // input zero wins: scan from the top so the lowest index is last
    always_comb begin
        found = 1'b0;
        level = 1'b0;
        for (int i = NUM - 1; i >= 0; i--) begin
            if (hit[i]) begin
                found = 1'b1;
                level = levels[i];
            end
        end
    end
endmodule

// [bench/udpot_cmd_model.sv]
// behavioural model of the isolated command inputs and the drive enable
`timescale 1ns/1ns
module udpot_cmd_model (
    // command routing
    input  wire logic [2:0] raiseIdx,
    input  wire logic [2:0] lowerIdx,
    input  wire logic [2:0] decoyRaiseIdx,
    input  wire logic [2:0] decoyLowerIdx,
    // operator commands
    input  wire logic       raiseOn,
    input  wire logic       lowerOn,
    input  wire logic       enOn,
    input  wire logic [7:0] noise,
    // pins
    output logic      [7:0] cmdInPin,
    output logic            driveEnPin
);
    // ======================================================================
    // pin levels
    // decoys show the opposite command, so a wrong priority pick shows at once
    always_comb begin
        cmdInPin = noise;
        cmdInPin[decoyRaiseIdx] = ~raiseOn;
        cmdInPin[decoyLowerIdx] = lowerOn;
        cmdInPin[raiseIdx] = raiseOn;
        cmdInPin[lowerIdx] = ~lowerOn;  // lower is active low
        driveEnPin = enOn;
    end
endmodule

// [bench/tb_top.sv]
// self-checking bench for the up/down speed reference core
`timescale 1ns/1ns
module tb_top;
    import udpot_pkg::*;
    // ======================================================================
    // signals
    logic        core_clk      = 1'h0;
    logic        rst_n         = 1'h0;
    logic [3:0]  regAddr       = 4'h0;
    logic [31:0] regWrData     = 32'h0000_0000;
    logic        regWr         = 1'h0;
    logic        regRd         = 1'h0;
    logic [31:0] regRdData_ff;
    logic [7:0]  cmdInPin;
    logic        driveEnPin;
    logic [15:0] speedRef_ff;
    logic        refValid_ff;
    logic        raiseAlarm_ff;
    logic        lowerAlarm_ff;
    logic        irq_ff;
    logic        raiseOn       = 1'h0;
    logic        lowerOn       = 1'h0;
    logic        enOn          = 1'h0;
    logic [7:0]  noise         = 8'h00;
    logic [2:0]  raiseIdx      = 3'h0;
    logic [2:0]  lowerIdx      = 3'h1;
    logic [15:0] minSpd;
    logic [15:0] maxSpd;
    logic [15:0] accStep;
    logic [15:0] decStep;
    logic [31:0] rdVal;
    logic [63:0] selWord;
    int          errTotal      = 0;
    int          samplesChecked = 0;
    // reset table: mapped registers plus one unmapped place
    logic [3:0]  rAddr [9] = '{ADDR_CTRL, ADDR_MINSPD, ADDR_MAXSPD, ADDR_ACCSTEP,
        ADDR_DECSTEP, ADDR_FUNCLO, ADDR_FUNCHI, ADDR_IRQMASK, 4'hF};
    logic [31:0] rVal  [9] = '{RST_CTRL, {16'h0000, RST_MINSPD}, {16'h0000, RST_MAXSPD},
        {16'h0000, RST_ACCSTEP}, {16'h0000, RST_DECSTEP}, RST_FUNC, RST_FUNC,
        32'h0000_0000, 32'h0000_0000};

    // ======================================================================
    // design and far-side model; a short tick keeps the ramps quick
    udpot_core #(.TICK_CYC(4)) i_dut (.core_clk(core_clk), .rst_n(rst_n),
        .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
        .regRdData_ff(regRdData_ff), .cmdInPin(cmdInPin), .driveEnPin(driveEnPin),
        .speedRef_ff(speedRef_ff), .refValid_ff(refValid_ff),
        .raiseAlarm_ff(raiseAlarm_ff), .lowerAlarm_ff(lowerAlarm_ff), .irq_ff(irq_ff));
    udpot_cmd_model i_model (.raiseIdx(raiseIdx), .lowerIdx(lowerIdx),
        .decoyRaiseIdx(raiseIdx + 3'h4), .decoyLowerIdx(lowerIdx + 3'h4),
        .raiseOn(raiseOn), .lowerOn(lowerOn), .enOn(enOn), .noise(noise),
        .cmdInPin(cmdInPin), .driveEnPin(driveEnPin));

    // clock at 10 MHz
    always #50 core_clk = ~core_clk;

    // ======================================================================
    // helpers
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        samplesChecked++;
        if (got !== exp) begin
            errTotal++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic regWrite(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'h1;
        @(posedge core_clk);
        regWr <= 1'h0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic checkReg(input logic [3:0] a, input logic [31:0] exp, input string what);
        @(posedge core_clk);
        regAddr <= a;
        regRd <= 1'h1;
        @(posedge core_clk);
        regRd <= 1'h0;
        #1;
        rdVal = regRdData_ff;
        check(what, exp, rdVal);
    endtask
    task automatic cmd(input logic r, input logic l, input logic e);
        @(posedge core_clk);
        raiseOn <= r;
        lowerOn <= l;
        enOn <= e;
        noise <= 8'($urandom);
    endtask
    function automatic logic [15:0] upNext(input logic [15:0] c);
        return (c + accStep > maxSpd) ? maxSpd : c + accStep;
    endfunction
    function automatic logic [15:0] dnNext(input logic [15:0] c);
        return (c < minSpd + decStep) ? minSpd : c - decStep;
    endfunction
    // every change of the reference must be exactly one clamped step
    task automatic watchRamp(input int n, input bit up);
        logic [15:0] prev;
        repeat (3) @(posedge core_clk);
        #1;
        prev = speedRef_ff;
        repeat (n) begin
            @(posedge core_clk);
            #1;
            if (speedRef_ff !== prev) begin
                check("ramp step", up ? upNext(prev) : dnNext(prev), speedRef_ff);
                prev = speedRef_ff;
            end
        end
    endtask
    task automatic waitRef(input logic [15:0] v, input string what);
        for (int i = 0; i < 60 && speedRef_ff !== v; i++) @(posedge core_clk);
        #1;
        check(what, v, speedRef_ff);
    endtask
    function automatic logic [63:0] sel(input logic [2:0] i, input logic [7:0] code);
        return {56'h0, code} << (8 * i);
    endfunction
    task automatic writeSel(input logic [63:0] s);
        regWrite(ADDR_FUNCLO, s[31:0]);
        regWrite(ADDR_FUNCHI, s[63:32]);
        repeat (3) @(posedge core_clk);
        #1;
    endtask

    task automatic tallyAndFinish();
        $display("checks %0d mismatches %0d", samplesChecked, errTotal);
        if (errTotal == 0 && samplesChecked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // watchdog: the sequence needs about twelve hundred cycles
    initial begin
        #2_000_000;
        errTotal++;
        tallyAndFinish();
    end

    // ======================================================================
    // main sequence
    initial begin
        void'($urandom(32'h0000_bbe2));
        raiseIdx = 3'($urandom % 3);
        lowerIdx = raiseIdx + 3'h1;
        minSpd = 16'h0064 + 16'($urandom % 16);
        maxSpd = minSpd + 16'h0028;
        accStep = 16'h0001 + 16'($urandom % 8);
        decStep = 16'h0001 + 16'($urandom % 8);
        repeat (3) @(posedge core_clk);
        rst_n <= 1'h1;
        repeat (2) @(posedge core_clk);
        #1;
        check("raise alarm", 32'h0000_0001, raiseAlarm_ff);
        check("lower alarm", 32'h0000_0001, lowerAlarm_ff);
        for (int i = 0; i < 9; i++) checkReg(rAddr[i], rVal[i], "reset value");
        checkReg(ADDR_STATE, {28'h0, STATE_BLOCKED}, "state blocked");
        checkReg(ADDR_IRQSTAT, 32'h0000_0003, "alarm events");
        regWrite(ADDR_MINSPD, {16'h0000, minSpd});
        regWrite(ADDR_MAXSPD, {16'h0000, maxSpd});
        regWrite(ADDR_ACCSTEP, {16'h0000, accStep});
        regWrite(ADDR_DECSTEP, {16'h0000, decStep});
        // two inputs per function; only the lower-numbered one may count
        selWord = sel(raiseIdx, FUNC_RAISE) | sel(lowerIdx, FUNC_LOWER);
        selWord |= sel(raiseIdx + 3'h4, FUNC_RAISE) | sel(lowerIdx + 3'h4, FUNC_LOWER);
        writeSel(selWord);
        check("raise alarm", 32'h0000_0000, raiseAlarm_ff);
        check("lower alarm", 32'h0000_0000, lowerAlarm_ff);
        checkReg(ADDR_IRQSTAT, 32'h0000_0003, "alarm events kept");
        checkReg(ADDR_IRQSTAT, 32'h0000_0000, "status cleared");
        regWrite(ADDR_CTRL, 32'h0000_0001);
        repeat (2) @(posedge core_clk);
        check("valid no source", 32'h0000_0000, refValid_ff);
        regWrite(ADDR_CTRL, 32'h0000_0071);
        repeat (2) @(posedge core_clk);
        check("valid", 32'h0000_0001, refValid_ff);
        checkReg(ADDR_STATE, {28'h0, STATE_RUNNING}, "state run");
        cmd(1'h0, 1'h0, 1'h1);
        waitRef(minSpd, "start at minimum");
        cmd(1'h1, 1'h0, 1'h1);
        watchRamp(300, 1'h1);
        check("at maximum", {16'h0, maxSpd}, {16'h0, speedRef_ff});
        regWrite(ADDR_SPEEDREF, 32'h0000_0000);
        cmd(1'h0, 1'h0, 1'h1);
        repeat (40) @(posedge core_clk);
        checkReg(ADDR_SPEEDREF, {16'h0, maxSpd}, "held reference");
        cmd(1'h0, 1'h1, 1'h1);
        watchRamp(20, 1'h0);
        cmd(1'h1, 1'h1, 1'h1);
        watchRamp(300, 1'h0);
        check("at minimum", {16'h0, minSpd}, {16'h0, speedRef_ff});
        cmd(1'h1, 1'h0, 1'h1);
        watchRamp(300, 1'h1);
        cmd(1'h0, 1'h1, 1'h0);
        repeat (30) @(posedge core_clk);
        cmd(1'h1, 1'h0, 1'h0);
        repeat (30) @(posedge core_clk);
        check("disabled hold", {16'h0, maxSpd}, {16'h0, speedRef_ff});
        cmd(1'h0, 1'h0, 1'h0);
        regWrite(ADDR_CTRL, 32'h0000_0073);
        cmd(1'h0, 1'h0, 1'h1);
        repeat (20) @(posedge core_clk);
        check("backup kept", {16'h0, maxSpd}, {16'h0, speedRef_ff});
        regWrite(ADDR_CTRL, 32'h0000_0071);
        cmd(1'h0, 1'h0, 1'h0);
        repeat (5) @(posedge core_clk);
        cmd(1'h0, 1'h0, 1'h1);
        waitRef(minSpd, "no backup restart");
        regWrite(ADDR_IRQMASK, 32'h0000_0004);
        cmd(1'h1, 1'h1, 1'h0);
        waitRef(ZERO_SPEED, "forced zero");
        repeat (2) @(posedge core_clk);
        check("irq zero", 32'h0000_0001, irq_ff);
        checkReg(ADDR_IRQSTAT, 32'h0000_0004, "zero event");
        cmd(1'h0, 1'h0, 1'h0);
        repeat (3) @(posedge core_clk);
        checkReg(ADDR_IRQSTAT, 32'h0000_0004, "zero event kept");
        repeat (2) @(posedge core_clk);
        #1;
        check("irq cleared", 32'h0000_0000, irq_ff);
        regWrite(ADDR_IRQMASK, 32'h0000_0001);
        writeSel(sel(lowerIdx, FUNC_LOWER) | sel(raiseIdx, 8'h16));
        check("raise alarm", 32'h0000_0001, raiseAlarm_ff);
        check("valid blocked", 32'h0000_0000, refValid_ff);
        check("irq raise", 32'h0000_0001, irq_ff);
        checkReg(ADDR_STATE, {28'h0, STATE_BLOCKED}, "state blocked");
        regWrite(ADDR_IRQMASK, 32'h0000_0000);
        repeat (2) @(posedge core_clk);
        check("irq masked", 32'h0000_0000, irq_ff);
        writeSel(sel(raiseIdx, FUNC_RAISE) | sel(lowerIdx, 8'h13));
        check("lower alarm", 32'h0000_0001, lowerAlarm_ff);
        check("raise alarm", 32'h0000_0000, raiseAlarm_ff);
        tallyAndFinish();
    end
endmodule
